// File: hw/byte_alu.sv
// Byte operator unit: one operand, an immediate byte and the carry flag.
// Assumes operands are stable during the cycle they are consumed.
`timescale 1ns/10ps
module byte_alu (
	input wire logic [2:0] op,
	input wire logic [7:0] operand,
	input wire logic [7:0] immediate_byte,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out,
	output logic carry_write
);

	logic [8:0] sum;

	always_comb
	begin
		sum = 9'h000;
		result = operand;
		carry_out = carry_in;
		carry_write = 1'b0;
		unique case (rw_alu_pkg::alu_op_t'(op))
			rw_alu_pkg::OP_LOAD: result = immediate_byte;
			rw_alu_pkg::OP_SHIFT_LEFT:
			begin
				result = {operand[6:0], carry_in};
				carry_out = operand[7];
				carry_write = 1'b1;
			end
			rw_alu_pkg::OP_OR: result = operand | immediate_byte;
			rw_alu_pkg::OP_XOR: result = operand ^ immediate_byte;
			rw_alu_pkg::OP_AND: result = operand & immediate_byte;
			rw_alu_pkg::OP_SHIFT_RIGHT:
			begin
				result = {carry_in, operand[7:1]};
				carry_out = operand[0];
				carry_write = 1'b1;
			end
			rw_alu_pkg::OP_ADD:
			begin
				sum = {1'b0, operand} + {1'b0, immediate_byte};
				result = sum[7:0];
				carry_out = sum[8];
				carry_write = 1'b1;
			end
			rw_alu_pkg::OP_ADDC:
			begin
				sum = {1'b0, operand} + {1'b0, immediate_byte}
					+ {8'h00, carry_in};
				result = sum[7:0];
				carry_out = sum[8];
				carry_write = 1'b1;
			end
		endcase
	end

endmodule

// File: hw/rw_alu.sv
// Register read/write datapath with an APB slave and a 128-byte file.
// Assumes one APB master; the sequencer writes instruction words over APB.
`timescale 1ns/10ps
module rw_alu (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic busy,
	output logic carry_flag
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	rw_alu_pkg::alu_state_t state, next_state;
	logic [7:0] file_mem [rw_alu_pkg::REG_COUNT];
	logic [7:0] first_byte_scratch_register, next_scratch;
	logic [31:0] instr, next_instr;
	logic [7:0] operand, next_operand;
	logic bad_opcode, next_bad_opcode;
	logic next_carry;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic file_we;
	logic [6:0] file_idx;
	logic [7:0] file_wdata;

	logic [2:0] opcode;
	logic [2:0] op;
	logic [6:0] addressed_register;
	logic [7:0] immediate_byte;
	logic [7:0] alu_result;
	logic alu_carry, alu_carry_write;

	assign opcode = instr[rw_alu_pkg::OPC_HI:rw_alu_pkg::OPC_LO];
	assign op = instr[rw_alu_pkg::OPR_HI:rw_alu_pkg::OPR_LO];
	assign addressed_register =
		instr[rw_alu_pkg::RA_HI:rw_alu_pkg::RA_LO];
	assign immediate_byte = instr[rw_alu_pkg::IMM_HI:rw_alu_pkg::IMM_LO];

	function automatic logic in_file(input logic [11:0] a);
		return a >= rw_alu_pkg::ADDR_FILE_BASE
			&& a <= rw_alu_pkg::ADDR_FILE_LAST && a[1:0] == 2'h0;
	endfunction

	function automatic logic [6:0] file_index(input logic [11:0] a);
		return a[8:2];
	endfunction

	byte_alu u_alu (
		.op(op),
		.operand(operand),
		.immediate_byte(immediate_byte),
		.carry_in(carry_flag),
		.result(alu_result),
		.carry_out(alu_carry),
		.carry_write(alu_carry_write)
	);

	// ------------------------------------------------------------
	// Sequencer and bus
	// ------------------------------------------------------------
	// Bus access waits while an instruction is in flight, so no reader can
	// see a register between its read and its write-back.
	logic access;
	logic commit;
	assign access = psel && penable && !pready;
	// A write lands at the edge that sees pready high, the edge at which
	// the master counts the transfer as done, and never on a refused one.
	assign commit = psel && penable && pready && pwrite && !pslverr;

	always_comb
	begin
		next_state = state;
		next_instr = instr;
		next_operand = operand;
		next_scratch = first_byte_scratch_register;
		next_carry = carry_flag;
		next_bad_opcode = bad_opcode;
		next_prdata = rw_alu_pkg::WORD_ZERO;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		file_we = 1'b0;
		file_idx = addressed_register;
		file_wdata = alu_result;
		unique case (state)
			rw_alu_pkg::ST_IDLE:
			begin
				if (access)
				begin
					next_pready = 1'b1;
					if (paddr == rw_alu_pkg::ADDR_INSTR)
					begin
						if (!pwrite)
							next_prdata = instr;
					end
					else if (paddr == rw_alu_pkg::ADDR_STATUS)
					begin
						if (!pwrite)
						begin
							next_prdata[rw_alu_pkg::STAT_CARRY] = carry_flag;
							next_prdata[rw_alu_pkg::STAT_BADOP] = bad_opcode;
						end
					end
					else if (paddr == rw_alu_pkg::ADDR_SCRATCH)
					begin
						if (!pwrite)
							next_prdata[7:0] = first_byte_scratch_register;
					end
					else if (in_file(paddr))
					begin
						if (!pwrite)
							next_prdata[7:0] = file_mem[file_index(paddr)];
					end
					else
						next_pslverr = 1'b1;
				end
				else if (commit)
				begin
					if (paddr == rw_alu_pkg::ADDR_INSTR)
					begin
						next_instr = pwdata;
						next_state = rw_alu_pkg::ST_READ;
					end
					else if (paddr == rw_alu_pkg::ADDR_STATUS)
						next_bad_opcode = 1'b0;
					else if (paddr == rw_alu_pkg::ADDR_SCRATCH)
						next_scratch = pwdata[7:0];
					else if (in_file(paddr))
					begin
						file_idx = file_index(paddr);
						file_wdata = pwdata[7:0];
						file_we = 1'b1;
					end
				end
			end
			rw_alu_pkg::ST_READ:
			begin
				next_state = rw_alu_pkg::ST_WRITE;
				if (opcode == rw_alu_pkg::OPC_FROM_SCRATCH)
					next_operand = first_byte_scratch_register;
				else
					next_operand = file_mem[addressed_register];
				if (opcode != rw_alu_pkg::OPC_RMW
					&& opcode != rw_alu_pkg::OPC_TO_SCRATCH
					&& opcode != rw_alu_pkg::OPC_FROM_SCRATCH)
				begin
					next_bad_opcode = 1'b1;
					next_state = rw_alu_pkg::ST_IDLE;
				end
			end
			rw_alu_pkg::ST_WRITE:
			begin
				next_state = rw_alu_pkg::ST_IDLE;
				if (alu_carry_write)
					next_carry = alu_carry;
				if (opcode == rw_alu_pkg::OPC_TO_SCRATCH)
					next_scratch = alu_result;
				else
					file_we = 1'b1;
			end
			default: next_state = rw_alu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= rw_alu_pkg::ST_IDLE;
			instr <= rw_alu_pkg::WORD_ZERO;
			operand <= rw_alu_pkg::BYTE_ZERO;
			first_byte_scratch_register <= rw_alu_pkg::BYTE_ZERO;
			carry_flag <= 1'b0;
			bad_opcode <= 1'b0;
			prdata <= rw_alu_pkg::WORD_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			state <= next_state;
			instr <= next_instr;
			operand <= next_operand;
			first_byte_scratch_register <= next_scratch;
			carry_flag <= next_carry;
			bad_opcode <= next_bad_opcode;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			busy <= next_state != rw_alu_pkg::ST_IDLE;
		end
	end

	// The file has no reset, to keep it plain storage: software must load a
	// register before an instruction reads it.
	always_ff @(posedge pclk)
	begin
		if (file_we)
			file_mem[file_idx] <= file_wdata;
	end

endmodule

// File: hw/rw_alu_pkg.sv
// Constants for the register read/write datapath of the script processor.
// Assumes a sequencer that presents one decoded instruction at a time.
package rw_alu_pkg;

	// ------------------------------------------------------------
	// APB register map
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_INSTR = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_SCRATCH = 12'h008;
	localparam logic [11:0] ADDR_FILE_BASE = 12'h200;
	localparam logic [11:0] ADDR_FILE_LAST = 12'h3FC;

	// ------------------------------------------------------------
	// Instruction fields, status bits and file size
	// ------------------------------------------------------------
	localparam int OPC_HI = 29;
	localparam int OPC_LO = 27;
	localparam int OPR_HI = 26;
	localparam int OPR_LO = 24;
	localparam int RA_HI = 22;
	localparam int RA_LO = 16;
	localparam int IMM_HI = 15;
	localparam int IMM_LO = 8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_CARRY = 1;
	localparam int STAT_BADOP = 2;
	localparam int REG_COUNT = 128;

	localparam logic [2:0] OPC_RMW = 3'h7;
	localparam logic [2:0] OPC_TO_SCRATCH = 3'h6;
	localparam logic [2:0] OPC_FROM_SCRATCH = 3'h5;

	typedef enum logic [2:0] {
		OP_LOAD = 3'h0,
		OP_SHIFT_LEFT = 3'h1,
		OP_OR = 3'h2,
		OP_XOR = 3'h3,
		OP_AND = 3'h4,
		OP_SHIFT_RIGHT = 3'h5,
		OP_ADD = 3'h6,
		OP_ADDC = 3'h7
	} alu_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_WRITE = 2'h2
	} alu_state_t;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// File: tb/apb_master.sv
// APB master standing in for the instruction sequencer.
// Assumes the slave ends each access with pready; the bench cuts hangs.
`timescale 1ns/10ps
module apb_master (
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// The request is held until pready is seen high at a rising edge.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
endmodule

// File: tb/rw_alu_asserts.sv
// Checker on the ports of the datapath.
// Assumes one clock and the active low reset presetn.
`timescale 1ns/10ps
module rw_alu_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic busy,
	input wire logic carry_flag
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic mapped;
	assign mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h008
		|| paddr >= 12'h200 && paddr <= 12'h3FC);
	sequence instr_done;
		pready && pwrite && !pslverr && paddr == 12'h000
			&& pwdata[29:27] >= 3'h5;
	endsequence
	sequence run_ends;
		busy ##[1:3] !busy;
	endsequence
	sequence access_start;
		$rose(penable) && psel;
	endsequence
	sequence carry_moves;
		$changed(carry_flag);
	endsequence
	// The instruction word reads back in full; every other word is a byte.
	sequence byte_read;
		pready && !pwrite && paddr != 12'h000;
	endsequence
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_cause_a: assert property (pready |-> $past(psel && penable))
		else $error("pready without access");
	ready_bound_a: assert property (access_start |-> ##[1:6] pready)
		else $error("access never ended");
	run_start_a: assert property (instr_done |=> run_ends)
		else $error("instruction did not run");
	carry_cause_a: assert property (carry_moves |-> $past(busy))
		else $error("carry moved while idle");
	err_cause_a: assert property (pslverr |-> pready && !mapped)
		else $error("error on mapped address");
	ok_access_a: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access refused");
	read_upper_a: assert property (byte_read |-> prdata[31:8] == 0)
		else $error("upper read bits set");
endmodule
bind rw_alu rw_alu_asserts chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .busy(busy), .carry_flag(carry_flag));

// File: tb/test_rw_alu.sv
// Bench for the datapath: each of the three valid opcodes with every operator over APB.
// Assumes the master model and the bound checker.
`timescale 1ns/10ps
module test_rw_alu;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, busy, carry_flag, c, e;
	logic [11:0] paddr, ra;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] a, s, imm, src, res;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	always #12.5 pclk = ~pclk;
	rw_alu dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
		.carry_flag(carry_flag));
	apb_master m (.pclk(pclk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	task close_out;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x)
		begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, g, x);
		end
	endtask
	task wr(input logic [11:0] ad, input logic [31:0] d);
		m.xfer(1'h1, ad, d, q, e);
	endtask
	task rd(input logic [11:0] ad);
		m.xfer(1'h0, ad, 32'h0000_0000, q, e);
	endtask
	// A stuck handshake ends the run well after the tests should be done.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			error_cnt++;
			close_out();
		end
	end
	initial
	begin
		c = 1'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		for (int o = 5; o < 8; o++)
			for (int p = 0; p < 8; p++)
			begin
				ra = 12'h200 + 12'((o * 21 + p * 13) % 128 * 4);
				a = 8'(8'hA5 + o * 37 + p * 11);
				s = 8'(8'h5A ^ (p * 29));
				imm = 8'(8'h3C + p * 17);
				wr(ra, {24'h000000, a});
				wr(12'h008, {24'h000000, s});
				wr(12'h000, {2'h3, 3'(o), 3'(p), 1'h0, ra[8:2], imm, 8'h00});
				@(negedge pclk);
				cmp({31'h0, busy}, 32'h0000_0001);
				src = (o == 5) ? s : a;
				case (p)
					0: res = imm;
					1: {c, res} = {src, c};
					2: res = src | imm;
					3: res = src ^ imm;
					4: res = src & imm;
					5: {res, c} = {c, src};
					6: {c, res} = src + imm;
					default: {c, res} = src + imm + c;
				endcase
				rd(ra);
				cmp(q, {24'h000000, o == 6 ? a : res});
				rd(12'h008);
				cmp(q, {24'h000000, o == 6 ? res : s});
				rd(12'h004);
				cmp({29'h0, busy, q[1], carry_flag},
					{29'h0, 1'h0, c, c});
			end
		// An opcode outside the class must set the bad opcode flag and leave the addressed register alone.
		wr(12'h200, 32'h0000_0033);
		wr(12'h000, 32'hD000_FF00);
		@(negedge pclk);
		cmp({31'h0, busy}, 32'h0000_0001);
		rd(12'h004);
		cmp({31'h0, q[2]}, 32'h0000_0001);
		rd(12'h000);
		cmp(q, 32'hD000_FF00);
		rd(12'h200);
		cmp(q, 32'h0000_0033);
		wr(12'h004, 32'h0000_0000);
		rd(12'h004);
		cmp({31'h0, q[2]}, 32'h0000_0000);
		rd(12'h100);
		cmp({31'h0, e}, 32'h0000_0001);
		rd(12'h201);
		cmp({31'h0, e}, 32'h0000_0001);
		close_out();
	end
endmodule
